// [src/fpdc_pkg.sv]
// Constants shared by the flash power-down host controller.
// Assumes a 100 MHz system clock and a x16 asynchronous parallel flash.
package fpdc_pkg;

  // ----------------------------------------
  // Clock and widths
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_W        = 18;
  localparam int DATA_W        = 16;
  localparam int CNT_W         = 16;

  // ----------------------------------------
  // Timing in ns and derived cycle counts
  // ----------------------------------------
  // Rounds a least time up to whole cycles, never below one
  function automatic logic [CNT_W-1:0] fpdc_min_cycles(input int t_ns);
    int c;
    c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c[CNT_W-1:0];
  endfunction : fpdc_min_cycles

  localparam int PD_PULSE_NS   = 100;
  localparam int WAKE_RD_NS    = 1000;
  localparam int WAKE_WR_NS    = 1000;
  localparam int READ_ACC_NS   = 90;
  localparam int WE_LOW_NS     = 50;
  localparam int WE_HIGH_NS    = 30;

  localparam logic [CNT_W-1:0] PD_PULSE_CYC = fpdc_min_cycles(PD_PULSE_NS);
  localparam logic [CNT_W-1:0] WAKE_RD_CYC  = fpdc_min_cycles(WAKE_RD_NS);
  localparam logic [CNT_W-1:0] WAKE_WR_CYC  = fpdc_min_cycles(WAKE_WR_NS);
  localparam logic [CNT_W-1:0] READ_ACC_CYC = fpdc_min_cycles(READ_ACC_NS);
  localparam logic [CNT_W-1:0] WE_LOW_CYC   = fpdc_min_cycles(WE_LOW_NS);
  localparam logic [CNT_W-1:0] WE_HIGH_CYC  = fpdc_min_cycles(WE_HIGH_NS);
  // Two synchroniser stages sit between the data pins and the capture
  localparam logic [CNT_W-1:0] SYNC_CYC     = 16'h0002;

  // ----------------------------------------
  // User command codes
  // ----------------------------------------
  localparam logic [1:0] OP_READ  = 2'h0;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_SLEEP = 2'h2;
  localparam logic [1:0] OP_WAKE  = 2'h3;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE    = 6'h01,
    ST_READ    = 6'h02,
    ST_WR_LOW  = 6'h04,
    ST_WR_HIGH = 6'h08,
    ST_PD_LOW  = 6'h10,
    ST_PD_HOLD = 6'h20
  } fpdc_state_type;

endpackage : fpdc_pkg

// [src/fpdc_sync.sv]
// Two-stage synchroniser for pins arriving from outside the clock domain.
// Assumes each bit is sampled independently; buses must be quasi-static.
`timescale 1ns/1ps
module fpdc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------
  // Stages
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : fpdc_sync

// [src/fpdc_host.sv]
// Host sequencer driving an asynchronous NOR flash: reads, command writes,
// deep power-down entry and exit. Assumes all flash pins are board-level
// and the user side is on clk_sys.
`timescale 1ns/1ps
// Contract
// - Host holds reset_powerdown_n low at least 100 ns.
// - No valid read data before wake_to_output_valid_time after wake.
// - Host waits wake_to_write_time after wake before any command write.
// - reset_powerdown_n follows the system reset.
// - Block erase needs erase data with an address inside the block.
// - Word or byte write needs write command and target address.
module fpdc_host
  import fpdc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire logic [1:0]        cmd_op,
  input  wire logic [ADDR_W-1:0] cmd_addr,
  input  wire logic [DATA_W-1:0] cmd_wdata,
  output logic                   rsp_valid,
  output logic      [DATA_W-1:0] rsp_rdata,
  output logic                   flash_busy,
  output logic                   powered_down,
  output logic                   chip_select_n,
  output logic                   output_enable_n,
  output logic                   write_strobe_n,
  output logic                   reset_powerdown_n,
  output logic      [ADDR_W-1:0] flash_addr,
  output logic      [DATA_W-1:0] data_pins_out,
  output logic                   data_pins_oe,
  input  wire logic [DATA_W-1:0] data_pins_in,
  input  wire logic              ready_busy_n
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  fpdc_state_type   state;
  logic [CNT_W-1:0] step_cnt;
  logic [CNT_W-1:0] wake_cnt;
  logic [DATA_W-1:0] data_sync;
  logic             rdy_sync;
  logic             take;
  logic             rd_ok;
  logic             wr_ok;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  fpdc_sync #(.WIDTH(DATA_W)) u_data_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in (data_pins_in),
    .sync_out (data_sync)
  );

  fpdc_sync #(.WIDTH(1)) u_rdy_sync (
    .clk_sys  (clk_sys),
    .srst     (srst),
    .async_in (ready_busy_n),
    .sync_out (rdy_sync)
  );

  // ----------------------------------------
  // Acceptance
  // ----------------------------------------
  // Reads and writes wait out their own wake-up intervals after power-down
  assign rd_ok = (wake_cnt >= WAKE_RD_CYC);
  assign wr_ok = (wake_cnt >= WAKE_WR_CYC);

  always_comb begin
    cmd_ready = 1'b0;
    unique case (cmd_op)
      OP_READ:  cmd_ready = (state == ST_IDLE) && rd_ok;
      OP_WRITE: cmd_ready = (state == ST_IDLE) && wr_ok;
      OP_SLEEP: cmd_ready = (state == ST_IDLE);
      OP_WAKE:  cmd_ready = (state == ST_PD_HOLD);
    endcase
  end

  assign take = cmd_valid && cmd_ready;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // System reset also drives the flash through a full power-down pulse
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state    <= ST_PD_LOW;
      step_cnt <= PD_PULSE_CYC;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (take) begin
            unique case (cmd_op)
              OP_READ: begin
                state    <= ST_READ;
                step_cnt <= CNT_W'(READ_ACC_CYC + SYNC_CYC);
              end
              OP_WRITE: begin
                state    <= ST_WR_LOW;
                step_cnt <= WE_LOW_CYC;
              end
              OP_SLEEP: begin
                state    <= ST_PD_LOW;
                step_cnt <= PD_PULSE_CYC;
              end
              OP_WAKE: begin
                state <= ST_IDLE;
              end
            endcase
          end
        end
        ST_READ: begin
          step_cnt <= step_cnt - 16'h0001;
          if (step_cnt == 16'h0001) begin
            state <= ST_IDLE;
          end
        end
        ST_WR_LOW: begin
          step_cnt <= step_cnt - 16'h0001;
          if (step_cnt == 16'h0001) begin
            state    <= ST_WR_HIGH;
            step_cnt <= WE_HIGH_CYC;
          end
        end
        ST_WR_HIGH: begin
          step_cnt <= step_cnt - 16'h0001;
          if (step_cnt == 16'h0001) begin
            state <= ST_IDLE;
          end
        end
        ST_PD_LOW: begin
          step_cnt <= step_cnt - 16'h0001;
          if (step_cnt == 16'h0001) begin
            state <= ST_PD_HOLD;
          end
        end
        ST_PD_HOLD: begin
          if (take) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Wake-up timer
  // ----------------------------------------
  // Saturates at the longer of the two intervals so it never wraps
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wake_cnt <= 16'h0000;
    end else if (state == ST_PD_LOW || state == ST_PD_HOLD) begin
      wake_cnt <= 16'h0000;
    end else if (!(rd_ok && wr_ok)) begin
      wake_cnt <= wake_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // Flash pins
  // ----------------------------------------
  // Write strobe rises one state before chip select, so it is the latching edge
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      chip_select_n     <= 1'b1;
      output_enable_n   <= 1'b1;
      write_strobe_n    <= 1'b1;
      reset_powerdown_n <= 1'b0;
      data_pins_oe      <= 1'b0;
    end else begin
      reset_powerdown_n <= !(state == ST_PD_LOW || state == ST_PD_HOLD) || take;
      if (state == ST_IDLE && take && cmd_op == OP_READ) begin
        chip_select_n   <= 1'b0;
        output_enable_n <= 1'b0;
      end else if (state == ST_IDLE && take && cmd_op == OP_WRITE) begin
        chip_select_n  <= 1'b0;
        write_strobe_n <= 1'b0;
        data_pins_oe   <= 1'b1;
      end else if (state == ST_READ && step_cnt == 16'h0001) begin
        chip_select_n   <= 1'b1;
        output_enable_n <= 1'b1;
      end else if (state == ST_WR_LOW && step_cnt == 16'h0001) begin
        write_strobe_n <= 1'b1;
      end else if (state == ST_WR_HIGH && step_cnt == 16'h0001) begin
        chip_select_n <= 1'b1;
        data_pins_oe  <= 1'b0;
      end else if (state == ST_PD_LOW || state == ST_PD_HOLD) begin
        chip_select_n   <= 1'b1;
        output_enable_n <= 1'b1;
        write_strobe_n  <= 1'b1;
        data_pins_oe    <= 1'b0;
      end
    end
  end

  // Address and data held from acceptance to the end of the cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flash_addr    <= '0;
      data_pins_out <= '0;
    end else if (take && (cmd_op == OP_READ || cmd_op == OP_WRITE)) begin
      flash_addr    <= cmd_addr;
      data_pins_out <= cmd_wdata;
    end
  end

  // ----------------------------------------
  // Read response and status
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= (state == ST_READ) && (step_cnt == 16'h0001);
      if (state == ST_READ && step_cnt == 16'h0001) begin
        rsp_rdata <= data_sync;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flash_busy   <= 1'b0;
      powered_down <= 1'b1;
    end else begin
      flash_busy   <= !rdy_sync;
      powered_down <= (state == ST_PD_LOW || state == ST_PD_HOLD);
    end
  end

endmodule : fpdc_host

// [test/fpdc_host_checker.sv]
// Pin-level assertions for the flash host sequencer.
// Assumes it is bound into fpdc_host and sees only its ports.
`timescale 1ns/1ps
module fpdc_host_checker (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic rsp_valid,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic reset_powerdown_n,
  input wire logic data_pins_oe
);
  // ----------------------------------------
  // Wake counter and properties
  // ----------------------------------------
  logic [7:0] wake_cnt;
  // Saturates so a long awake period never wraps into a false early access
  always_ff @(posedge clk_sys) begin
    if (srst || !reset_powerdown_n) begin
      wake_cnt <= 8'h00;
    end else if (wake_cnt != 8'hff) begin
      wake_cnt <= wake_cnt + 8'h01;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_we_low;
    !write_strobe_n [*5] ##1 write_strobe_n;
  endsequence
  sequence s_cs_hold;
    !chip_select_n [*3] ##1 chip_select_n;
  endsequence
  a_strobe_exclusive: assert property (output_enable_n || write_strobe_n)
    else $error("read and write strobes low together");
  a_write_select: assert property (!write_strobe_n |-> !chip_select_n)
    else $error("write strobe without chip select");
  a_strobe_width: assert property ($fell(write_strobe_n) |-> s_we_low)
    else $error("write strobe low time wrong");
  a_latch_edge: assert property ($rose(write_strobe_n) |-> s_cs_hold)
    else $error("chip select rose before write strobe");
  a_sleep_quiet: assert property (!reset_powerdown_n |-> chip_select_n && output_enable_n
    && write_strobe_n && !data_pins_oe)
    else $error("pins active in power-down");
  a_pulse_width: assert property ($fell(reset_powerdown_n) |->
    !reset_powerdown_n [*8] ##1 !reset_powerdown_n [*2])
    else $error("power-down pulse too short");
  a_reset_sleep: assert property (disable iff (1'b0) srst |=> !reset_powerdown_n)
    else $error("system reset left flash awake");
  a_wake_read: assert property ($fell(output_enable_n) |-> wake_cnt >= 8'h64)
    else $error("read too soon after wake");
  a_wake_write: assert property ($fell(write_strobe_n) |-> wake_cnt >= 8'h64)
    else $error("write too soon after wake");
  a_read_answer: assert property ($fell(output_enable_n) |->
    ##11 rsp_valid ##1 !rsp_valid)
    else $error("read answer timing wrong");
endmodule : fpdc_host_checker

bind fpdc_host fpdc_host_checker fpdc_host_checker_i (.clk_sys(clk_sys), .srst(srst),
  .rsp_valid(rsp_valid), .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
  .write_strobe_n(write_strobe_n), .reset_powerdown_n(reset_powerdown_n),
  .data_pins_oe(data_pins_oe));

// [test/fpdc_flash_model.sv]
// Behavioural x16 flash: array reads, word program, power-down, abort.
// Assumes supplies valid; only read-array mode is modelled.
`timescale 1ns/1ps
module fpdc_flash_model
  import fpdc_pkg::*;
#(
  parameter int PROG_NS  = 2000,
  parameter int ABORT_NS = 500,
  parameter int WAKE_NS  = 900
) (
  input  wire logic              chip_select_n,
  input  wire logic              output_enable_n,
  input  wire logic              write_strobe_n,
  input  wire logic              reset_powerdown_n,
  input  wire logic [ADDR_W-1:0] flash_addr,
  input  wire logic [DATA_W-1:0] data_pins_out,
  input  wire logic              data_pins_oe,
  output logic      [DATA_W-1:0] data_pins_in,
  output logic                   ready_busy_n
);
  // ----------------------------------------
  // Array, program and power-down
  // ----------------------------------------
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] last = 16'h0000;
  logic [DATA_W-1:0] pd;
  logic              awake = 1'b0;
  int                pa;
  int                gen = 0;
  int                mine;
  initial ready_busy_n = 1'b1;
  function automatic logic [DATA_W-1:0] word_at(input int a);
    return mem.exists(a) ? mem[a] : a[15:0] ^ 16'h5a5a;
  endfunction : word_at
  always @(reset_powerdown_n) begin
    awake = 1'b0;
    if (reset_powerdown_n) begin
      #(WAKE_NS) awake = reset_powerdown_n;
    end
  end
  always @(negedge reset_powerdown_n) begin
    if (!ready_busy_n) begin
      gen++;
      mem[pa] = ~pd;
      #(ABORT_NS) ready_busy_n = 1'b1;
    end
  end
  // Blocks while programming, so writes during busy are dropped
  always @(posedge write_strobe_n or posedge chip_select_n) begin
    if (reset_powerdown_n && ready_busy_n && (chip_select_n != write_strobe_n)) begin
      pa = flash_addr;
      pd = data_pins_oe ? data_pins_out : ~data_pins_out;
      gen++;
      mine = gen;
      ready_busy_n = 1'b0;
      #(PROG_NS);
      if (gen == mine) begin
        mem[pa] = pd;
        ready_busy_n = 1'b1;
      end
    end
  end
  always @(output_enable_n or chip_select_n or awake or flash_addr) begin
    data_pins_in = (awake && !chip_select_n && !output_enable_n) ? word_at(flash_addr)
      : ~last;
    last = data_pins_in;
  end
endmodule : fpdc_flash_model

// [test/flash_powerdown_cmd_interface_test.sv]
// Self-checking bench: host sequencer against the flash model.
// Assumes package timing; a run of about 1300 cycles.
`timescale 1ns/1ps
module flash_powerdown_cmd_interface_test
  import fpdc_pkg::*;
;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic              clk_sys = 1'b0, srst, cmd_valid, cmd_ready, rsp_valid, flash_busy;
  logic              powered_down, chip_select_n, output_enable_n, write_strobe_n;
  logic              reset_powerdown_n, data_pins_oe, ready_busy_n;
  logic [1:0]        cmd_op;
  logic [ADDR_W-1:0] cmd_addr, flash_addr, a;
  logic [DATA_W-1:0] cmd_wdata, rsp_rdata, data_pins_out, data_pins_in, flash_dq, lfsr;
  logic [DATA_W-1:0] exp_mem [int];
  int                failures = 0, tests_run = 0, cyc = 0, take, t_wake, n;
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc++;
  assign data_pins_in = data_pins_oe ? data_pins_out : flash_dq;
  fpdc_host fpdc_host_i (.clk_sys(clk_sys), .srst(srst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .flash_busy(flash_busy),
    .powered_down(powered_down), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .reset_powerdown_n(reset_powerdown_n), .flash_addr(flash_addr),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
    .data_pins_in(data_pins_in), .ready_busy_n(ready_busy_n));
  fpdc_flash_model fpdc_flash_model_i (.chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_strobe_n(write_strobe_n),
    .reset_powerdown_n(reset_powerdown_n), .flash_addr(flash_addr),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe),
    .data_pins_in(flash_dq), .ready_busy_n(ready_busy_n));
  function automatic logic [15:0] next_rand(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : next_rand
  function automatic logic [15:0] exp_word(input int x);
    return exp_mem.exists(x) ? exp_mem[x] : x[15:0] ^ 16'h5a5a;
  endfunction : exp_word
  task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic cycles(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cycles
  // Ready is looked at on the falling edge, where it has settled
  task automatic issue(input logic [1:0] op, input logic [17:0] ad, input logic [15:0] d);
    int k;
    k = 0;
    cmd_op = op;
    cmd_addr = ad;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(negedge clk_sys);
    while (cmd_ready !== 1'b1 && k < 2000) begin
      k++;
      @(negedge clk_sys);
    end
    if (k >= 2000) failures++;
    cycles(1);
    take = cyc;
    cmd_valid = 1'b0;
  endtask : issue
  task automatic read_chk(input logic [17:0] ad, input string what);
    int k;
    k = 0;
    issue(OP_READ, ad, 16'h0000);
    while (rsp_valid !== 1'b1 && k < 50) begin
      k++;
      @(negedge clk_sys);
    end
    if (k >= 50) failures++;
    check(what, exp_word(ad), rsp_rdata);
    // Back onto the rising-edge grid so the next request starts just after an edge
    cycles(1);
  endtask : read_chk
  task automatic wait_idle();
    n = 0;
    while (flash_busy !== 1'b0 && n < 1000) begin
      n++;
      cycles(1);
    end
    if (n >= 1000) failures++;
  endtask : wait_idle
  initial begin
    srst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = 18'h00000;
    cmd_wdata = 16'h0000;
    lfsr = 16'h0011;
    cycles(2);
    srst = 1'b0;
    check("rp_n after reset", 16'h0000, {15'h0000, reset_powerdown_n});
    check("read refused asleep", 16'h0000, {15'h0000, cmd_ready});
    issue(OP_WAKE, 18'h00000, 16'h0000);
    t_wake = take;
    read_chk(18'h00005, "read after wake");
    check("wake gap", 16'h0001, {15'h0000, (take - t_wake) >= 100});
    for (int i = 0; i < 4; i++) begin
      lfsr = next_rand(lfsr);
      a = {2'h0, lfsr};
      lfsr = next_rand(lfsr);
      issue(OP_WRITE, a, lfsr);
      exp_mem[a] = lfsr;
      cycles(20);
      check("busy", 16'h0001, {15'h0000, flash_busy});
      wait_idle();
      read_chk(a, "readback");
      read_chk(a ^ 18'h00001, "neighbour");
    end
    issue(OP_WRITE, 18'h00100, next_rand(lfsr));
    cycles(20);
    issue(OP_SLEEP, 18'h00000, 16'h0000);
    cycles(20);
    check("asleep", 16'h0001, {15'h0000, powered_down});
    wait_idle();
    check("abort ends early", 16'h0001, {15'h0000, n < 100});
    issue(OP_WAKE, 18'h00000, 16'h0000);
    read_chk(a, "after abort");
    stop_test();
  end
  // Whole run is near 1300 cycles; the limit of 30000 cycles allows over twenty times that
  initial begin
    #300000;
    failures++;
    stop_test();
  end
endmodule : flash_powerdown_cmd_interface_test
